// ---- rtl/upc_regs.sv ----
// Avalon-MM register bank for the USB PHY common block controls
`timescale 1ns/1ps
// Contract
// - Bank at base 1200h: common 000h, analog 0C4h, upstream 0C8h, interchip 140h.
// - Bit 31 set gates off the common block register clock.
// - Bit 24 selects functional (0) or test (1) signals into common block.
// - Bit 23 selects limited (0) or increased (1) crystal drive amplitude.
// - Bit 19 selects 25 MHz (0, reset) or 24 MHz (1) PLL reference.
// - Read-only bit 18 shows core ready, forced low without I/O power-on.
// - Bit 17 enables USB PLL fast startup.
// - Fast-start default from external image, else OTP image, else zero.
// - External image flag chosen by current bus speed, high or full.
// - Bus reset or lite reset restores fast-start to last loaded image value.
// - Bit 16 enables the USB PLL, reset value one.
// - Bit 15 low powers down bias and PLL, overriding all port suspends.
// - Bit 14 low powers down the crystal oscillator block.
// - Read-only bit 12 reports PLL clocks usable, reset zero.
// - Bit 9 set disables the front-end ready timer.
// - Bit 0 forces every clock gating cell into bypass.
module upc_regs
  import upc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [12:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        core_supply_ready_raw,
  input  wire logic        io_power_on_raw,
  input  wire logic        pll_lock_raw,
  input  wire logic        ext_image_present,
  input  wire logic        ext_fast_start_hs,
  input  wire logic        ext_fast_start_fs,
  input  wire logic        otp_image_present,
  input  wire logic        otp_fast_start,
  input  wire logic        bus_high_speed,
  input  wire logic        image_load,
  input  wire logic        bus_reset,
  input  wire logic        lite_reset,
  output logic             common_clock_gate_off,
  output logic             common_test_signal_select,
  output logic             crystal_drive_level,
  output logic             pll_reference_select,
  output logic             pll_fast_start_enable,
  output logic             usb_pll_enable,
  output logic             common_power_down_n,
  output logic             crystal_power_down_n,
  output logic             port_suspend_override,
  output logic             frontend_ready_timer_disable,
  output logic             global_gating_bypass,
  output logic [31:0]      phy_analog_test_ctrl_q,
  output logic [31:0]      phy_upstream_analog_ctrl_q,
  output logic [31:0]      interchip_port_enable_q
);

  // Pin synchronisers; first stage read only by second stage
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {pll_lock_raw, io_power_on_raw, core_supply_ready_raw};
      sync_b <= sync_a;
    end
  end

  // Byte-lane merge used by every writable register
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction

  // Address decode; bank sits at a fixed base
  wire logic [12:0] rel          = avs_address - BANK_BASE;
  wire logic        in_bank      = (avs_address >= BANK_BASE);
  wire logic        hit_common   = in_bank && (rel == OFS_COMMON_TEST);
  wire logic        hit_analog   = in_bank && (rel == OFS_ANALOG_TEST);
  wire logic        hit_upstream = in_bank && (rel == OFS_UPSTREAM);
  wire logic        hit_inter    = in_bank && (rel == OFS_INTERCHIP);

  // One wait state: request answered on the second edge it is held
  logic        busy;
  wire logic   take  = (avs_read || avs_write) && busy;
  wire logic   wr_ok = avs_write && take;

  logic [31:0] common;
  logic [31:0] analog;
  logic [31:0] upstream;
  logic [31:0] inter;
  logic        fast_start_image;

  // Fast-start image: external by speed, else OTP, else zero
  wire logic ext_flag  = bus_high_speed ? ext_fast_start_hs : ext_fast_start_fs;
  wire logic img_value = ext_image_present ? ext_flag :
                         (otp_image_present ? otp_fast_start : 1'b0);
  wire logic restore   = bus_reset || lite_reset;

  // Writes land only on writable common bits; reserved stay zero
  wire logic [31:0] common_wr = merge(common, avs_writedata, avs_byteenable) & COMMON_WR_MASK;

  // Core ready gated by I/O power-on
  wire logic core_ready = sync_b[0] && sync_b[1];

  wire logic [31:0] common_rd = (common & COMMON_WR_MASK)
                              | (32'(core_ready) << BIT_CORE_READY)
                              | (32'(sync_b[2]) << BIT_CLK_USABLE);

  wire logic [31:0] rd_mux = hit_common   ? common_rd :
                             hit_analog   ? analog :
                             hit_upstream ? upstream :
                             hit_inter    ? inter : UNMAPPED_DATA;

  // Handshake
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) busy <= 1'b0;
    else busy <= (avs_read || avs_write) && !busy;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) avs_waitrequest <= 1'b1;
    else avs_waitrequest <= !((avs_read || avs_write) && !busy);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) avs_readdata <= 32'h0;
    else if (avs_read && !busy) avs_readdata <= rd_mux;
  end

  // Image value latched whenever a load is signalled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) fast_start_image <= 1'b0;
    else if (image_load) fast_start_image <= img_value;
  end

  // Common test register; reset restore wins over a write to bit 17
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      common <= COMMON_RESET;
    end else begin
      if (wr_ok && hit_common) common <= common_wr;
      if (restore) common[BIT_FAST_START] <= fast_start_image;
      else if (image_load) common[BIT_FAST_START] <= img_value;
    end
  end

  // Other slots held as plain storage; their fields live elsewhere
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analog   <= OTHER_RESET;
      upstream <= OTHER_RESET;
      inter    <= OTHER_RESET;
    end else if (wr_ok) begin
      if (hit_analog)   analog   <= merge(analog, avs_writedata, avs_byteenable);
      if (hit_upstream) upstream <= merge(upstream, avs_writedata, avs_byteenable);
      if (hit_inter)    inter    <= merge(inter, avs_writedata, avs_byteenable);
    end
  end

  // Registered control outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      common_clock_gate_off        <= 1'b0;
      common_test_signal_select    <= 1'b0;
      crystal_drive_level          <= 1'b0;
      pll_reference_select         <= 1'b0;
      pll_fast_start_enable        <= 1'b0;
      usb_pll_enable               <= COMMON_RESET[BIT_PLL_ENABLE];
      common_power_down_n          <= 1'b0;
      crystal_power_down_n         <= 1'b0;
      port_suspend_override        <= !COMMON_RESET[BIT_COMMON_PD_N];
      frontend_ready_timer_disable <= 1'b0;
      global_gating_bypass         <= 1'b0;
      phy_analog_test_ctrl_q       <= OTHER_RESET;
      phy_upstream_analog_ctrl_q   <= OTHER_RESET;
      interchip_port_enable_q      <= OTHER_RESET;
    end else begin
      common_clock_gate_off        <= common[BIT_CLOCK_DISABLE];
      common_test_signal_select    <= common[BIT_TEST_SELECT];
      crystal_drive_level          <= common[BIT_XTAL_DRIVE];
      pll_reference_select         <= common[BIT_REF_SELECT];
      pll_fast_start_enable        <= common[BIT_FAST_START];
      usb_pll_enable               <= common[BIT_PLL_ENABLE];
      common_power_down_n          <= common[BIT_COMMON_PD_N];
      crystal_power_down_n         <= common[BIT_XTAL_PD_N];
      port_suspend_override        <= !common[BIT_COMMON_PD_N];
      frontend_ready_timer_disable <= common[BIT_AFE_TIMER_DIS];
      global_gating_bypass         <= common[BIT_GATING_BYPASS];
      phy_analog_test_ctrl_q       <= analog;
      phy_upstream_analog_ctrl_q   <= upstream;
      interchip_port_enable_q      <= inter;
    end
  end

endmodule

// ---- inc/upc_pkg.sv ----
// Register map, field positions and reset values of the USB PHY common control bank
package upc_pkg;
  localparam logic [12:0] BANK_BASE        = 13'h1200;
  localparam logic [12:0] OFS_COMMON_TEST  = 13'h0000;
  localparam logic [12:0] OFS_ANALOG_TEST  = 13'h00c4;
  localparam logic [12:0] OFS_UPSTREAM     = 13'h00c8;
  localparam logic [12:0] OFS_INTERCHIP    = 13'h0140;
  localparam int BIT_CLOCK_DISABLE   = 31;
  localparam int BIT_TEST_SELECT     = 24;
  localparam int BIT_XTAL_DRIVE      = 23;
  localparam int BIT_REF_SELECT      = 19;
  localparam int BIT_CORE_READY      = 18;
  localparam int BIT_FAST_START      = 17;
  localparam int BIT_PLL_ENABLE      = 16;
  localparam int BIT_COMMON_PD_N     = 15;
  localparam int BIT_XTAL_PD_N       = 14;
  localparam int BIT_CLK_USABLE      = 12;
  localparam int BIT_AFE_TIMER_DIS   = 9;
  localparam int BIT_GATING_BYPASS   = 0;
  // Writable bits of the common test register
  localparam logic [31:0] COMMON_WR_MASK = 32'h818bc201;
  localparam logic [31:0] COMMON_RESET   = 32'h00010000;
  localparam logic [31:0] OTHER_RESET    = 32'h00000000;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h00000000;
endpackage

// ---- sim/upc_properties.sv ----
// Port-level checks for the common control register bank
`timescale 1ns/1ps
module upc_properties (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [12:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        common_clock_gate_off,
  input wire logic        common_test_signal_select,
  input wire logic        pll_reference_select,
  input wire logic        global_gating_bypass,
  input wire logic        port_suspend_override,
  input wire logic        common_power_down_n
);
  // Completing accesses; writes assume all byte lanes on
  wire  wr_com = avs_write && !avs_waitrequest && avs_address == 13'h1200;
  wire  rd_ok  = avs_read && !avs_waitrequest;
  logic up;
  // Outputs hold reset values until one edge after release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) up <= 1'b0;
    else up <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no answer after one wait state");
  wait_short_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer stood longer than one cycle");
  unmapped_zero_a: assert property (rd_ok && !(avs_address inside {13'h1200, 13'h12c4, 13'h12c8, 13'h1340})
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (rd_ok && avs_address == 13'h1200 |-> (avs_readdata & ~32'h818fd201) == 32'h0)
    else $error("reserved bits not zero");
  suspend_override_a: assert property (up |-> port_suspend_override != common_power_down_n)
    else $error("override does not follow power down");
  gate_off_a: assert property (wr_com |-> ##2 common_clock_gate_off == $past(avs_writedata[31], 2))
    else $error("clock gate off wrong");
  gating_bypass_a: assert property (wr_com |-> ##2 global_gating_bypass == $past(avs_writedata[0], 2))
    else $error("gating bypass wrong");
  ref_select_a: assert property (wr_com |-> ##2 pll_reference_select == $past(avs_writedata[19], 2))
    else $error("reference select wrong");
  test_select_a: assert property (wr_com |-> ##2 common_test_signal_select == $past(avs_writedata[24], 2))
    else $error("test select wrong");
  cover property (wr_com);
  cover property (rd_ok && avs_address == 13'h1200);
  cover property (rd_ok && avs_address == 13'h1204);
endmodule
bind upc_regs upc_properties chk (.*);

// ---- sim/test_upc_regs.sv ----
// Self-checking bench for the common control register bank
`timescale 1ns/1ps
module test_upc_regs;
  import upc_pkg::*;
  logic clk = 0, arst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest, image_load = 0;
  logic [12:0] avs_address = 13'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, phy_analog_test_ctrl_q;
  logic [31:0] phy_upstream_analog_ctrl_q, interchip_port_enable_q;
  logic [3:0]  avs_byteenable = 4'hf;
  logic core_supply_ready_raw = 0, io_power_on_raw = 0, pll_lock_raw = 0, ext_image_present = 0;
  logic ext_fast_start_hs = 0, ext_fast_start_fs = 0, otp_image_present = 0, otp_fast_start = 0;
  logic bus_high_speed = 0, bus_reset = 0, lite_reset = 0, common_clock_gate_off, crystal_drive_level;
  logic common_test_signal_select, pll_reference_select, pll_fast_start_enable, usb_pll_enable;
  logic common_power_down_n, crystal_power_down_n, port_suspend_override;
  logic frontend_ready_timer_disable, global_gating_bypass;
  int err_total = 0, compares = 0, cyc = 0;
  upc_regs dut (.*);
  // Clock and hang guard
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  // One Avalon access; the idle edge after it avoids a double assignment
  task automatic bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // One-cycle strobe: bit 0 image load, bit 1 bus reset, bit 2 lite reset
  task automatic pulse(input logic [2:0] sel);
    {lite_reset, bus_reset, image_load} <= sel;
    @(posedge clk);
    {lite_reset, bus_reset, image_load} <= 3'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic t_reset;
    bus(0, 13'h1200, 0);
    chk(rd, 32'h00010000, "common reset");
    chk(usb_pll_enable, 1, "pll enable out");
    bus(0, 13'h1204, 0); // holes are only ever read, never written
    chk(rd, 32'h0, "hole read");
  endtask
  task automatic t_fields(input logic [31:0] d);
    bus(1, 13'h1200, d);
    bus(0, 13'h1200, 0);
    chk(rd, d & COMMON_WR_MASK, "common readback");
    chk({common_clock_gate_off, common_test_signal_select, crystal_drive_level, pll_reference_select,
         pll_fast_start_enable, usb_pll_enable, common_power_down_n, crystal_power_down_n,
         frontend_ready_timer_disable, global_gating_bypass, port_suspend_override},
        {d[31], d[24], d[23], d[19], d[17], d[16], d[15], d[14], d[9], d[0], !d[15]},
        "control outputs");
  endtask
  task automatic t_status;
    {core_supply_ready_raw, io_power_on_raw, pll_lock_raw} <= 3'h7;
    repeat (5) @(posedge clk);
    bus(0, 13'h1200, 0);
    chk(rd, 32'h00041000, "status set");
    io_power_on_raw <= 1'b0;
    repeat (5) @(posedge clk);
    bus(0, 13'h1200, 0);
    chk(rd, 32'h00001000, "core ready gated");
  endtask
  task automatic t_others;
    bus(1, 13'h12c4, 32'ha5a5c3c3);
    bus(1, 13'h12c8, 32'h5a5a3c3c);
    bus(1, 13'h1340, 32'h0f0f00ff);
    bus(0, 13'h12c8, 0);
    chk(rd, 32'h5a5a3c3c, "upstream read");
    chk(phy_analog_test_ctrl_q, 32'ha5a5c3c3, "analog copy");
    chk(phy_upstream_analog_ctrl_q, 32'h5a5a3c3c, "upstream copy");
    chk(interchip_port_enable_q, 32'h0f0f00ff, "interchip copy");
    // Only byte lane 1 may change
    avs_byteenable <= 4'h2;
    bus(1, 13'h12c4, 32'hffffffff);
    avs_byteenable <= 4'hf;
    bus(0, 13'h12c4, 0);
    chk(rd, 32'ha5a5ffc3, "lane merge");
  endtask
  task automatic fs_chk(input logic e);
    bus(0, 13'h1200, 0);
    chk(rd[17], e, "fast start");
  endtask
  // Image loads by speed, restores, then fallbacks to OTP and zero
  task automatic t_fast;
    {ext_image_present, ext_fast_start_hs, bus_high_speed} <= 3'h7;
    pulse(3'h1);
    fs_chk(1);
    bus(1, 13'h1200, 0);
    pulse(3'h2);
    fs_chk(1);
    bus(1, 13'h1200, 0);
    pulse(3'h4);
    fs_chk(1);
    bus_high_speed <= 1'b0;
    pulse(3'h1);
    fs_chk(0);
    {ext_image_present, otp_image_present, otp_fast_start} <= 3'h3;
    pulse(3'h1);
    fs_chk(1);
    otp_image_present <= 1'b0;
    pulse(3'h1);
    fs_chk(0);
  endtask
  task automatic conclude;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_fields(32'hfff7ffff); // reference select kept at 25 MHz
    t_fields(32'h0);
    t_status;
    t_others;
    t_fast;
    conclude;
  end
endmodule
